/* logic/flash_ctl_pkg.sv */
package flash_ctl_pkg;
	localparam int PAGE_COUNT = 64;
	localparam int PAGE_BYTES = 2048;
	localparam int WORD_ADDR_W = 15;
	localparam int BYTES_PER_WORD = 4;
	localparam int TIMER_W = 24;

	localparam logic [7:0] OFS_ADDR_HIGH = 8'h00;
	localparam logic [7:0] OFS_ADDR_LOW = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_WRITE_DATA = 8'h0C;
	localparam logic [7:0] OFS_TIMING = 8'h10;

	localparam int CTL_ERASE_BIT = 0;
	localparam int CTL_WRITE_BIT = 1;
	localparam int CTL_CHIP_BIT = 2;
	localparam int CTL_VIOL_BIT = 5;
	localparam int CTL_SWBUSY_BIT = 6;
	localparam int CTL_BUSY_BIT = 7;
	localparam int PAGE_LSB = 1;
	localparam int PAGE_MSB = 6;

	localparam logic [6:0] ADDR_HIGH_RST = 7'h00;
	localparam logic [7:0] ADDR_LOW_RST = 8'h00;
	localparam logic [7:0] TIMING_RST = 8'h00;
	localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;

	localparam int CLK_MHZ = 50;
	localparam int WORD_PROG_US = 20;
	localparam int PAGE_ERASE_MS = 20;
	localparam int CHIP_ERASE_MS = 200;
	localparam int WORD_PROG_CYC = WORD_PROG_US * CLK_MHZ;
	localparam int PAGE_ERASE_CYC = PAGE_ERASE_MS * 1000 * CLK_MHZ;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ERASE = 2'b01,
		ST_COLLECT = 2'b11,
		ST_PROGRAM = 2'b10
	} seq_state_type;
endpackage

/* logic/op_timer.sv */
`timescale 1ns/1ns
// Counts ticks, each tick being scale+1 clocks; done marks the last cycle
module op_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [flash_ctl_pkg::TIMER_W-1:0] ticks,
	input wire logic [7:0] scale,
	output logic done
);
	logic [flash_ctl_pkg::TIMER_W-1:0] cnt_r;
	logic [7:0] pre_r;
	logic running_r;
	wire tick = running_r & (pre_r == 8'h00);

	assign done = tick & (cnt_r == flash_ctl_pkg::TIMER_W'(1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r <= '0;
			pre_r <= 8'h00;
			running_r <= 1'b0;
		end
		else if (start)
		begin
			cnt_r <= ticks;
			pre_r <= scale;
			running_r <= 1'b1;
		end
		else if (tick)
		begin
			cnt_r <= cnt_r - flash_ctl_pkg::TIMER_W'(1);
			pre_r <= scale;
			running_r <= ~done;
		end
		else if (running_r)
			pre_r <= pre_r - 8'h01;
	end
endmodule

/* logic/embedded_flash_write_controller.sv */
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module embedded_flash_write_controller #(
	parameter int unsigned PAGE_ERASE_CYCLES = flash_ctl_pkg::PAGE_ERASE_CYC,
	parameter int unsigned CHIP_ERASE_CYCLES = flash_ctl_pkg::CHIP_ERASE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fetch_from_flash,
	input wire logic flash_access,
	output logic cpu_hold,
	output logic dma_trigger,
	output logic array_program,
	output logic array_erase_page,
	output logic array_erase_chip,
	output logic [14:0] array_word_addr,
	output logic [5:0] array_page,
	output logic [31:0] array_wdata
);
	flash_ctl_pkg::seq_state_type state_r, state_nxt;
	logic [6:0] addr_high_r;
	logic [7:0] addr_low_r;
	logic [7:0] timing_r;
	logic chip_r, chip_nxt;
	logic write_pend_r, write_pend_nxt;
	logic [1:0] byte_cnt_r;
	logic [23:0] word_buf_r;
	logic viol_r;
	logic hold_src_r, hold_src_nxt;
	logic dma_trigger_r, cpu_hold_r;
	logic array_program_r, array_erase_page_r, array_erase_chip_r;
	logic [31:0] array_wdata_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r;
	logic [flash_ctl_pkg::TIMER_W-1:0] prog_cyc_r;
	logic timer_done;

	// Register bus decode; one wait state so read data comes from a flop
	wire apb_access = psel & penable & ~pready_r;
	wire apb_done = psel & penable & pready_r;
	wire hit_high = paddr == flash_ctl_pkg::OFS_ADDR_HIGH;
	wire hit_low = paddr == flash_ctl_pkg::OFS_ADDR_LOW;
	wire hit_ctl = paddr == flash_ctl_pkg::OFS_CONTROL;
	wire hit_data = paddr == flash_ctl_pkg::OFS_WRITE_DATA;
	wire hit_time = paddr == flash_ctl_pkg::OFS_TIMING;
	wire addr_hit = hit_high | hit_low | hit_ctl | hit_data | hit_time;
	wire wr_en = apb_done & pwrite & ~pslverr_r;
	wire is_idle = state_r == flash_ctl_pkg::ST_IDLE;
	wire is_erase = state_r == flash_ctl_pkg::ST_ERASE;
	wire is_collect = state_r == flash_ctl_pkg::ST_COLLECT;
	wire is_program = state_r == flash_ctl_pkg::ST_PROGRAM;
	wire ctl_wr = wr_en & hit_ctl;
	wire cfg_wr = wr_en & is_idle;
	wire want_erase = pwdata[flash_ctl_pkg::CTL_ERASE_BIT];
	wire want_chip = pwdata[flash_ctl_pkg::CTL_CHIP_BIT];
	wire want_write = pwdata[flash_ctl_pkg::CTL_WRITE_BIT];
	wire launch_idle = ctl_wr & is_idle;
	// Bytes outside a sequence or during programming are dropped
	wire byte_wr = wr_en & hit_data & is_collect;
	wire last_byte = byte_wr &
		(byte_cnt_r == 2'(flash_ctl_pkg::BYTES_PER_WORD - 1));
	wire viol_clr = ctl_wr & pwdata[flash_ctl_pkg::CTL_VIOL_BIT];
	wire viol_set = flash_access & is_program;
	wire [14:0] word_addr = {addr_high_r, addr_low_r};
	wire [14:0] word_addr_inc = word_addr + 15'h0001;
	wire busy = ~is_idle;
	wire [7:0] ctl_read = {busy, is_program, viol_r, 2'b00, chip_r & is_erase,
		write_pend_r, is_erase};
	wire [7:0] rd_byte = hit_high ? {1'b0, addr_high_r} :
		hit_low ? addr_low_r :
		hit_ctl ? ctl_read :
		hit_time ? timing_r : 8'h00;
	wire timer_start = (state_nxt != state_r) &
		((state_nxt == flash_ctl_pkg::ST_ERASE) |
		(state_nxt == flash_ctl_pkg::ST_PROGRAM));
	wire [flash_ctl_pkg::TIMER_W-1:0] ticks_sel = is_collect ?
		flash_ctl_pkg::TIMER_W'(flash_ctl_pkg::WORD_PROG_CYC) :
		want_chip ? flash_ctl_pkg::TIMER_W'(CHIP_ERASE_CYCLES) :
		flash_ctl_pkg::TIMER_W'(PAGE_ERASE_CYCLES);
	// Trigger on entry to collect and after each byte that is not a fourth
	wire trig_nxt = (state_nxt == flash_ctl_pkg::ST_COLLECT) &
		(~is_collect | (byte_wr & ~last_byte));
	wire hold_nxt = hold_src_nxt & ((state_nxt == flash_ctl_pkg::ST_ERASE) |
		(state_nxt == flash_ctl_pkg::ST_PROGRAM));

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			flash_ctl_pkg::ST_IDLE:
				if (launch_idle & (want_erase | want_chip))
					state_nxt = flash_ctl_pkg::ST_ERASE;
				else if (launch_idle & want_write)
					state_nxt = flash_ctl_pkg::ST_COLLECT;
			flash_ctl_pkg::ST_ERASE:
				if (timer_done)
					state_nxt = write_pend_r ? flash_ctl_pkg::ST_COLLECT :
						flash_ctl_pkg::ST_IDLE;
			flash_ctl_pkg::ST_COLLECT:
				if (ctl_wr & ~want_write)
					state_nxt = flash_ctl_pkg::ST_IDLE;
				else if (last_byte)
					state_nxt = flash_ctl_pkg::ST_PROGRAM;
			flash_ctl_pkg::ST_PROGRAM:
				if (timer_done)
					state_nxt = flash_ctl_pkg::ST_COLLECT;
			default:
				state_nxt = flash_ctl_pkg::ST_IDLE;
		endcase
	end

	assign chip_nxt = launch_idle ? want_chip : chip_r;
	assign write_pend_nxt = (state_nxt == flash_ctl_pkg::ST_IDLE) ? 1'b0 :
		launch_idle ? want_write : write_pend_r;
	// Stall only code that runs from flash; RAM code keeps running
	assign hold_src_nxt = timer_start ? fetch_from_flash : hold_src_r;

	op_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(timer_start),
		.ticks(ticks_sel),
		.scale(timing_r),
		.done(timer_done)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end
		else
		begin
			pready_r <= apb_access;
			pslverr_r <= apb_access & ~addr_hit;
			if (apb_access & ~pwrite)
				prdata_r <= {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_high_r <= flash_ctl_pkg::ADDR_HIGH_RST;
			addr_low_r <= flash_ctl_pkg::ADDR_LOW_RST;
			timing_r <= flash_ctl_pkg::TIMING_RST;
		end
		else if (is_program & timer_done)
			{addr_high_r, addr_low_r} <= word_addr_inc;
		else
		begin
			if (cfg_wr & hit_high)
				addr_high_r <= pwdata[6:0];
			if (cfg_wr & hit_low)
				addr_low_r <= pwdata[7:0];
			if (cfg_wr & hit_time)
				timing_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= flash_ctl_pkg::ST_IDLE;
			chip_r <= 1'b0;
			write_pend_r <= 1'b0;
			hold_src_r <= 1'b0;
			viol_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			chip_r <= chip_nxt;
			write_pend_r <= write_pend_nxt;
			hold_src_r <= hold_src_nxt;
			viol_r <= viol_set | (viol_r & ~viol_clr);
		end
	end

	// A shift register keeps the first byte at the bottom
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			byte_cnt_r <= 2'b00;
			word_buf_r <= 24'h000000;
		end
		else if (~is_collect)
			byte_cnt_r <= 2'b00;
		else if (byte_wr)
		begin
			byte_cnt_r <= byte_cnt_r + 2'b01;
			word_buf_r <= {pwdata[7:0], word_buf_r[23:8]};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			array_wdata_r <= flash_ctl_pkg::ERASED_WORD;
		else if (last_byte)
			array_wdata_r <= {pwdata[7:0], word_buf_r};
		else if (state_nxt == flash_ctl_pkg::ST_ERASE)
			array_wdata_r <= flash_ctl_pkg::ERASED_WORD;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dma_trigger_r <= 1'b0;
			cpu_hold_r <= 1'b0;
			array_program_r <= 1'b0;
			array_erase_page_r <= 1'b0;
			array_erase_chip_r <= 1'b0;
		end
		else
		begin
			dma_trigger_r <= trig_nxt;
			cpu_hold_r <= hold_nxt;
			array_program_r <= state_nxt == flash_ctl_pkg::ST_PROGRAM;
			array_erase_page_r <= (state_nxt == flash_ctl_pkg::ST_ERASE) &
				~chip_nxt;
			array_erase_chip_r <= (state_nxt == flash_ctl_pkg::ST_ERASE) &
				chip_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign dma_trigger = dma_trigger_r;
	assign cpu_hold = cpu_hold_r;
	assign array_program = array_program_r;
	assign array_erase_page = array_erase_page_r;
	assign array_erase_chip = array_erase_chip_r;
	assign array_wdata = array_wdata_r;
	assign array_word_addr = word_addr;
	// Six page bits select one of the 64 erase units
	assign array_page = addr_high_r[flash_ctl_pkg::PAGE_MSB:
		flash_ctl_pkg::PAGE_LSB];

	// Cycles spent programming, checked against the nominal duration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prog_cyc_r <= '0;
		else if (is_program)
			prog_cyc_r <= prog_cyc_r + flash_ctl_pkg::TIMER_W'(1);
		else
			prog_cyc_r <= '0;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_PROG_ON_FOURTH: assert property (
		last_byte |=> is_program && array_program)
		else $error("fourth byte did not start programming");
	AST_LSB_FIRST: assert property (last_byte |=> array_wdata ==
		{$past(pwdata[7:0]), $past(word_buf_r)})
		else $error("word assembled in wrong byte order");
	AST_WORD_TIME: assert property (is_program && timer_done &&
		timing_r == 8'h00 |-> prog_cyc_r ==
		flash_ctl_pkg::TIMER_W'(flash_ctl_pkg::WORD_PROG_CYC - 1))
		else $error("word programming time wrong");
	AST_SWBUSY_CLEARS: assert property (is_program && timer_done
		|=> !is_program && dma_trigger ##1 !dma_trigger)
		else $error("single write busy did not clear");
	AST_ERASE_FIRST: assert property (launch_idle && want_erase
		&& want_write |=> is_erase && write_pend_r)
		else $error("erase did not precede write");
	AST_START_TRIGGER: assert property (launch_idle && want_write
		&& !want_erase && !want_chip |=> dma_trigger && is_collect)
		else $error("write start gave no dma trigger");
	AST_TRIGGER_READY: assert property (dma_trigger |-> is_collect)
		else $error("dma trigger while not ready for data");
	AST_VIOLATION: assert property (flash_access && is_program
		|=> viol_r)
		else $error("access during busy not flagged");
	// Hold drops in the first collect cycle, so that cycle is excluded
	AST_HOLD_FROM_FLASH: assert property (timer_start
		&& fetch_from_flash |=> cpu_hold until !busy || is_collect)
		else $error("flash code not held");
	AST_RAM_NO_STALL: assert property (timer_start
		&& !fetch_from_flash |=> !cpu_hold)
		else $error("ram code stalled");
	AST_ADDR_STEP: assert property (is_program && timer_done
		|=> array_word_addr == $past(word_addr_inc))
		else $error("word address did not advance");
	AST_ERASE_ONES: assert property (array_erase_page
		|| array_erase_chip |-> array_wdata == flash_ctl_pkg::ERASED_WORD)
		else $error("erase not driving ones");
	AST_BUSY_READ: assert property (apb_access && !pwrite
		&& hit_ctl |=> prdata[7] == $past(busy))
		else $error("busy bit read wrong");
endmodule

/* tb/cpu_dma_model.sv */
`timescale 1ns/1ns
// Register bus master of the CPU plus one byte-wide DMA channel
module cpu_dma_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dma_trigger
);
	logic [7:0] dma_q[$];
	int trig_n = 0;
	int served_n = 0;
	logic hung = 1'b0;
	logic [31:0] dma_rdata;
	logic dma_err;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// Entered just after a rising edge; returns one idle edge later
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		hung = hung | (n >= 50);
		@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask

	// Pulses last one cycle, so they are counted apart from serving
	always @(negedge pclk)
		if (dma_trigger === 1'b1)
			trig_n++;

	// A trigger seen with nothing queued is lost, as on an unarmed channel
	initial
		forever
		begin
			@(posedge pclk);
			if (trig_n > served_n)
			begin
				served_n = trig_n;
				if (dma_q.size() > 0)
					xfer(1'b1, flash_ctl_pkg::OFS_WRITE_DATA,
						{24'h000000, dma_q.pop_front()}, dma_rdata, dma_err);
			end
		end
endmodule

/* tb/embedded_flash_write_controller_bench.sv */
`timescale 1ns/1ns
module embedded_flash_write_controller_bench;
	localparam int PE_CYC = 50;
	localparam int CE_CYC = 100;
	localparam int W_CYC = flash_ctl_pkg::WORD_PROG_CYC;
	localparam logic [7:0] CTL = flash_ctl_pkg::OFS_CONTROL;
	localparam logic [7:0] WDAT = flash_ctl_pkg::OFS_WRITE_DATA;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic fetch_from_flash = 1'b0;
	logic flash_access = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, cpu_hold, dma_trigger, e;
	logic array_program, array_erase_page, array_erase_chip;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, array_wdata, q;
	logic [14:0] array_word_addr;
	logic [5:0] array_page;
	logic [7:0] bytes[8] = '{8'h12, 8'h34, 8'h56, 8'h78,
		8'h9A, 8'hBC, 8'hDE, 8'hF0};
	int bad_count = 0;
	int samples_checked = 0;
	int hi_cyc[3] = '{0, 0, 0};
	int base;
	int t0;

	embedded_flash_write_controller #(.PAGE_ERASE_CYCLES(PE_CYC),
		.CHIP_ERASE_CYCLES(CE_CYC)) u_embedded_flash_write_controller (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu_hold(cpu_hold),
		.fetch_from_flash(fetch_from_flash), .flash_access(flash_access),
		.dma_trigger(dma_trigger), .array_program(array_program),
		.array_erase_page(array_erase_page), .array_page(array_page),
		.array_erase_chip(array_erase_chip), .array_wdata(array_wdata),
		.array_word_addr(array_word_addr));

	cpu_dma_model u_cpu_dma_model (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dma_trigger(dma_trigger));

	initial
	begin
		forever
			#10 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		hi_cyc[0] += int'(array_program);
		hi_cyc[1] += int'(array_erase_page);
		hi_cyc[2] += int'(array_erase_chip);
	end

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_cpu_dma_model.xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		u_cpu_dma_model.xfer(1'b0, a, 32'h00000000, q, e);
		check(q, exp);
	endtask

	// Waits until some array operation runs (busy=1) or none does
	task automatic wait_ops(input logic busy);
		int n;
		for (n = 0; n < 5000; n++)
		begin
			@(negedge pclk);
			if ((array_program | array_erase_page | array_erase_chip) === busy)
				break;
		end
		if (n >= 5000)
		begin
			$display("mismatch at %0t: array operation wait ran out", $time);
			bad_count++;
			print_verdict();
		end
		@(posedge pclk);
	endtask

	initial
	begin
		for (int n = 0; n < 20000 && u_cpu_dma_model.hung !== 1'b1; n++)
			@(posedge pclk);
		$display("mismatch at %0t: run did not finish", $time);
		bad_count++;
		print_verdict();
	end

	initial
	begin
		@(negedge pclk);
		check(array_wdata, flash_ctl_pkg::ERASED_WORD);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a <= 16; a += 4)
			rd(8'(a), 32'h00000000);
		u_cpu_dma_model.xfer(1'b0, 8'h14, 32'h00000000, q, e);
		check(32'(e), 32'h1);
		wr(flash_ctl_pkg::OFS_ADDR_HIGH, 32'hFFFFFF85);
		wr(flash_ctl_pkg::OFS_ADDR_LOW, 32'h000000FF);
		rd(flash_ctl_pkg::OFS_ADDR_HIGH, 32'h00000005);
		t0 = u_cpu_dma_model.trig_n;
		wr(CTL, 32'h00000002);
		rd(CTL, 32'h00000082);
		base = hi_cyc[0];
		for (int i = 0; i < 4; i++)
			wr(WDAT, {24'h000000, bytes[i]});
		@(negedge pclk);
		check(32'(array_program), 32'h1);
		check(array_wdata, 32'h78563412);
		check(32'(array_word_addr), 32'h05FF);
		check(32'(cpu_hold), 32'h0);
		@(posedge pclk);
		flash_access <= 1'b1;
		@(posedge pclk);
		flash_access <= 1'b0;
		rd(CTL, 32'h000000E2);
		wr(WDAT, 32'h00000055);
		for (int i = 4; i < 8; i++)
			u_cpu_dma_model.dma_q.push_back(bytes[i]);
		wait_ops(1'b0);
		check(32'(hi_cyc[0] - base), 32'(W_CYC));
		wait_ops(1'b1);
		check(array_wdata, 32'hF0DEBC9A);
		check(32'(array_word_addr), 32'h0600);
		wait_ops(1'b0);
		repeat (2) @(posedge pclk);
		check(32'(u_cpu_dma_model.trig_n - t0), 32'h9);
		wr(CTL, 32'h00000000);
		wr(CTL, 32'h00000020);
		rd(CTL, 32'h00000000);
		wr(flash_ctl_pkg::OFS_TIMING, 32'h00000001);
		wr(flash_ctl_pkg::OFS_ADDR_HIGH, 32'h0000000B);
		fetch_from_flash <= 1'b1;
		for (int i = 0; i < 4; i++)
			u_cpu_dma_model.dma_q.push_back(bytes[i]);
		t0 = u_cpu_dma_model.trig_n;
		base = hi_cyc[1];
		wr(CTL, 32'h00000003);
		@(negedge pclk);
		check(32'(array_erase_page), 32'h1);
		check(32'(array_page), 32'h05);
		check(array_wdata, flash_ctl_pkg::ERASED_WORD);
		check(32'(cpu_hold), 32'h1);
		check(32'(u_cpu_dma_model.trig_n - t0), 32'h0);
		base = hi_cyc[0] - base;
		wait_ops(1'b0);
		check(32'(hi_cyc[1] - (hi_cyc[0] - base)), 32'(2 * PE_CYC));
		base = hi_cyc[0];
		wait_ops(1'b1);
		check(32'(u_cpu_dma_model.trig_n - t0), 32'h4);
		check(32'(array_word_addr), 32'h0B01);
		check(array_wdata, 32'h78563412);
		wait_ops(1'b0);
		check(32'(hi_cyc[0] - base), 32'(2 * W_CYC));
		wr(CTL, 32'h00000000);
		fetch_from_flash <= 1'b0;
		wr(flash_ctl_pkg::OFS_TIMING, 32'h00000000);
		base = hi_cyc[2];
		wr(CTL, 32'h00000004);
		rd(CTL, 32'h00000085);
		wr(flash_ctl_pkg::OFS_ADDR_LOW, 32'h00000033);
		wait_ops(1'b0);
		check(32'(hi_cyc[2] - base), 32'(CE_CYC));
		rd(flash_ctl_pkg::OFS_ADDR_LOW, 32'h00000002);
		print_verdict();
	end
endmodule
